// *** design/wwdt_consts.svh ***
// constant values for the windowed watchdog
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

`define WWDT_RESTART_ADDR 16'hFF9B
`define WWDT_CFG_ADDR 16'h0080
`define WWDT_KEY 8'hAC
`define WWDT_RST_EN 8'h9A
`define WWDT_RST_DIS 8'h1A
`define WWDT_LOCK_BIT 0
`define WWDT_SEL_LSB 1
`define WWDT_EN_BIT 4
`define WWDT_WIN_LSB 5
`define WWDT_OVF_BASE 10
`define WWDT_CNT_W 18
`define WWDT_EXEMPT_LO 16'hFB00
`define WWDT_CAUSE_BIT 4
`define WWDT_CLK_PERIOD_NS 10

`endif

// *** design/wwdt_pkg.sv ***
// types shared by the windowed watchdog files
package wwdt_pkg;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic bit_op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } wwdt_bus_type;

    typedef struct packed {
        logic [15:0] rom_top;
        logic [15:0] xram_bot;
        logic [15:0] xram_top;
        logic [15:0] iram_bot;
    } wwdt_map_type;

    typedef struct packed {
        logic overflow;
        logic bad_key;
        logic bit_access;
        logic closed_write;
        logic bad_fetch;
        logic bad_data;
    } wwdt_cause_type;

    typedef enum logic [2:0] {
        WWDT_IDLE = 3'b001,
        WWDT_RUN = 3'b010,
        WWDT_TRIP = 3'b100
    } wwdt_state_type;

endpackage : wwdt_pkg

// *** design/wwdt_sync.sv ***
// two-stage synchroniser for levels entering the clk domain
`timescale 1ns/1ps
module wwdt_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            // reset high: a pin already high after reset is not taken as a rising edge
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : wwdt_sync

// *** design/wwdt_top.sv ***
// windowed watchdog timer on the slow oscillator
`timescale 1ns/1ps
`include "wwdt_consts.svh"
module wwdt_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // nonvolatile configuration byte
    input wire logic [7:0] option_cfg,
    // slow oscillator clock pin and its stop bit
    input wire logic slow_osc_clk,
    input wire logic slow_osc_stop_bit,
    // cpu power states
    input wire logic cpu_halt,
    input wire logic cpu_stop,
    // register access from the cpu
    input wire wwdt_pkg::wwdt_bus_type cpu_bus,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // memory access monitor
    input wire wwdt_pkg::wwdt_map_type mem_map,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic data_valid,
    input wire logic [15:0] data_addr,
    // reset controller side
    input wire logic cause_clr,
    output logic wdt_reset_req,
    output logic wd_reset_cause_flag,
    output wwdt_pkg::wwdt_cause_type trip_cause,
    output logic [7:0] reset_cause_bits,
    output logic counting
);
    import wwdt_pkg::*;

    localparam int CW = `WWDT_CNT_W;

    // configuration caught at reset
    logic [7:0] cfg_ff;
    logic count_enable_cfg;
    logic slow_osc_lock_cfg;
    logic overflow_sel_b2;
    logic overflow_sel_b1;
    logic overflow_sel_b0;
    logic open_frac_b1;
    logic open_frac_b0;
    logic [2:0] ovf_sel;
    logic [1:0] open_sel;

    // slow clock edge detection
    logic slow_sync;
    logic slow_prev_ff;
    logic slow_tick;
    logic frozen;
    logic run_tick;

    // counter and window
    wwdt_state_type state_ff;
    wwdt_state_type nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic [CW-1:0] period;
    logic [CW-1:0] ovf_last;
    logic [CW-1:0] quarter;
    logic [CW-1:0] close_end;
    logic window_open;
    logic first_done_ff;
    logic nxt_first_done;

    // pending restart writes
    logic restart_wr;
    logic write_bad;
    logic pend_ff;
    logic pend_bad_ff;
    logic pend_bit_ff;
    logic consume;

    // trip sources
    logic detect_en;
    logic fetch_legal;
    logic data_legal;
    logic fetch_trip;
    logic data_trip;
    wwdt_cause_type slow_cause;
    wwdt_cause_type fast_cause;
    wwdt_cause_type all_cause;
    logic trip;

    // registered outputs
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic reset_req_ff;
    logic cause_flag_ff;
    wwdt_cause_type cause_ff;

    // nonvolatile byte is sampled while reset is held
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_ff <= option_cfg;
        end
    end

    assign count_enable_cfg = cfg_ff[`WWDT_EN_BIT];
    assign slow_osc_lock_cfg = cfg_ff[`WWDT_LOCK_BIT];
    assign overflow_sel_b0 = cfg_ff[`WWDT_SEL_LSB];
    assign overflow_sel_b1 = cfg_ff[`WWDT_SEL_LSB+1];
    assign overflow_sel_b2 = cfg_ff[`WWDT_SEL_LSB+2];
    assign open_frac_b0 = cfg_ff[`WWDT_WIN_LSB];
    assign open_frac_b1 = cfg_ff[`WWDT_WIN_LSB+1];
    assign ovf_sel = {overflow_sel_b2, overflow_sel_b1, overflow_sel_b0};
    assign open_sel = {open_frac_b1, open_frac_b0};

    // slow oscillator pin enters through two flops
    wwdt_sync #(
        .WIDTH(1)
    ) u_slow_sync (
        .clk(clk),
        .srst(srst),
        .async_in(slow_osc_clk),
        .sync_out(slow_sync)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            // matches the synchroniser reset level, so no false tick follows reset
            slow_prev_ff <= 1'b1;
        end else begin
            slow_prev_ff <= slow_sync;
        end
    end

    // one enable pulse per slow oscillator rising edge
    assign slow_tick = slow_sync & ~slow_prev_ff;

    // halt, stop or oscillator stop only freeze when the lock bit is low
    assign frozen = ~slow_osc_lock_cfg & (cpu_halt | cpu_stop | slow_osc_stop_bit);

    // no flash programming input: self-programming never stops the count
    assign run_tick = slow_tick & ~frozen;

    // overflow period and window boundary
    always_comb begin
        period = CW'(1) << (`WWDT_OVF_BASE + ovf_sel);
        ovf_last = period - CW'(1);
        quarter = period >> 2;
        case (open_sel)
            2'b00: begin
                close_end = period - quarter;
            end
            2'b01: begin
                close_end = quarter << 1;
            end
            2'b10: begin
                close_end = quarter;
            end
            default: begin
                close_end = '0;
            end
        endcase
    end

    // closed from zero up to the boundary, open from there to overflow
    assign window_open = (cnt_ff >= close_end);

    // restart register writes from the cpu
    assign restart_wr = cpu_bus.wr_en & (cpu_bus.addr == `WWDT_RESTART_ADDR);
    assign write_bad = cpu_bus.bit_op | (cpu_bus.wdata != `WWDT_KEY);

    // a write waits here until the next running slow tick takes it
    assign consume = run_tick & (state_ff == WWDT_RUN) & pend_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            pend_ff <= 1'b0;
            pend_bad_ff <= 1'b0;
            pend_bit_ff <= 1'b0;
        end else begin
            // a write landing in the consume cycle is kept for the next tick
            pend_ff <= (pend_ff & ~consume) | restart_wr;
            pend_bad_ff <= (pend_bad_ff & ~consume) | (restart_wr & write_bad);
            pend_bit_ff <= (pend_bit_ff & ~consume) | (restart_wr & cpu_bus.bit_op);
        end
    end

    // counter sequencing in the slow domain
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_first_done = first_done_ff;
        slow_cause = '0;
        case (state_ff)
            WWDT_IDLE: begin
                if (count_enable_cfg) begin
                    nxt_state = WWDT_RUN;
                end
            end
            WWDT_RUN: begin
                if (run_tick) begin
                    if (pend_ff) begin
                        // restart is checked before overflow so a late key wins
                        if (pend_bad_ff) begin
                            slow_cause.bad_key = ~pend_bit_ff | (pend_bad_ff & ~pend_bit_ff);
                            slow_cause.bit_access = pend_bit_ff;
                        end else if (first_done_ff & ~window_open) begin
                            slow_cause.closed_write = 1'b1;
                        end else begin
                            // restart waits for a synced tick, so the period may shift by up to one tick
                            nxt_cnt = '0;
                            nxt_first_done = 1'b1;
                        end
                    end else if (cnt_ff == ovf_last) begin
                        slow_cause.overflow = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff + CW'(1);
                    end
                end
            end
            WWDT_TRIP: begin
                nxt_state = WWDT_TRIP;
            end
            default: begin
                nxt_state = WWDT_IDLE;
            end
        endcase
        if (trip) begin
            nxt_state = WWDT_TRIP;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= WWDT_IDLE;
            cnt_ff <= '0;
            first_done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            first_done_ff <= nxt_first_done;
        end
    end

    // illegal access checks run on the cpu clock, no waiting for a tick
    assign detect_en = count_enable_cfg & (state_ff == WWDT_RUN);

    assign fetch_legal = (fetch_addr <= mem_map.rom_top)
        | ((fetch_addr >= mem_map.xram_bot) & (fetch_addr <= mem_map.xram_top))
        | (fetch_addr >= mem_map.iram_bot);

    assign data_legal = (data_addr <= mem_map.rom_top)
        | ((data_addr >= mem_map.xram_bot) & (data_addr <= mem_map.xram_top))
        | (data_addr >= mem_map.iram_bot)
        | (data_addr >= `WWDT_EXEMPT_LO);

    assign fetch_trip = detect_en & fetch_valid & ~fetch_legal;
    assign data_trip = detect_en & data_valid & ~data_legal;

    always_comb begin
        fast_cause = '0;
        fast_cause.bad_fetch = fetch_trip;
        fast_cause.bad_data = data_trip;
    end

    assign all_cause = slow_cause | fast_cause;
    assign trip = (state_ff == WWDT_RUN) & (|all_cause);

    // reset request pulse and the reason behind it
    always_ff @(posedge clk) begin
        if (srst) begin
            reset_req_ff <= 1'b0;
            cause_ff <= '0;
        end else begin
            reset_req_ff <= trip;
            if (trip) begin
                cause_ff <= all_cause;
            end
        end
    end

    // cause flag: a new trip wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cause_flag_ff <= 1'b0;
        end else begin
            cause_flag_ff <= (cause_flag_ff & ~cause_clr) | trip;
        end
    end

    // reads show the reset value, never what was written
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= 1'b0;
            if (cpu_bus.rd_en & (cpu_bus.addr == `WWDT_RESTART_ADDR)) begin
                rd_data_ff <= count_enable_cfg ? `WWDT_RST_EN : `WWDT_RST_DIS;
                rd_valid_ff <= 1'b1;
            end else if (cpu_bus.rd_en & (cpu_bus.addr == `WWDT_CFG_ADDR)) begin
                rd_data_ff <= cfg_ff;
                rd_valid_ff <= 1'b1;
            end
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign wdt_reset_req = reset_req_ff;
    assign wd_reset_cause_flag = cause_flag_ff;
    assign trip_cause = cause_ff;
    assign counting = (state_ff == WWDT_RUN) & ~frozen;

    always_comb begin
        reset_cause_bits = 8'h00;
        reset_cause_bits[`WWDT_CAUSE_BIT] = cause_flag_ff;
    end

endmodule : wwdt_top

// *** tb/tb_wwdt_top.sv ***
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`include "wwdt_consts.svh"
module tb_wwdt_top;
    import wwdt_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic slow_osc_clk = 1'b0;
    logic [7:0] option_cfg = 8'h71;
    logic slow_osc_stop_bit = 1'b0;
    logic cpu_halt = 1'b0;
    logic cpu_stop = 1'b0;
    logic cause_clr = 1'b0;
    wwdt_map_type mem_map = '{16'h3FFF, 16'h8000, 16'h8FFF, 16'hFC00};
    wwdt_bus_type cpu_bus;
    wwdt_cause_type trip_cause;
    logic [7:0] rd_data, reset_cause_bits, d;
    logic rd_valid, fetch_valid, data_valid, wdt_reset_req, wd_reset_cause_flag, counting, v;
    logic [15:0] fetch_addr, data_addr;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    always #5 clk = ~clk;
    // slow tick of 80 ns keeps the longest wait near 8200 cycles
    always #40 slow_osc_clk = ~slow_osc_clk;
    wwdt_top dut (.clk, .srst, .option_cfg, .slow_osc_clk, .slow_osc_stop_bit, .cpu_halt,
        .cpu_stop, .cpu_bus, .rd_data, .rd_valid, .mem_map, .fetch_valid, .fetch_addr,
        .data_valid, .data_addr, .cause_clr, .wdt_reset_req, .wd_reset_cause_flag,
        .trip_cause, .reset_cause_bits, .counting);
    wwdt_cpu_model cpu (.clk, .cpu_bus, .rd_data, .rd_valid, .fetch_valid, .fetch_addr,
        .data_valid, .data_addr);
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rst(input logic [7:0] cfg, input logic [2:0] frz);
        @(posedge clk);
        srst <= 1'b1;
        option_cfg <= cfg;
        {slow_osc_stop_bit, cpu_halt, cpu_stop} <= frz;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
    endtask : rst
    task automatic wait_req(input int max);
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < max) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_req
    task automatic rd_chk(input logic [7:0] e);
        cpu.rd(`WWDT_RESTART_ADDR, d, v);
        chk("read strobe", v, 1'b1);
        chk("read value", d, e);
    endtask : rd_chk
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        #800000;
        error_cnt++;
        finish_test();
    end
    initial begin
        rst(8'h61, 3'b000);
        rd_chk(8'h1A);
        chk("counting", counting, 1'b0);
        cpu.acc(1'b1, 16'hF000);
        wait_req(30);
        chk("no trip", wdt_reset_req, 1'b0);
        $display("test disabled done");
        rst(8'h71, 3'b000);
        rd_chk(8'h9A);
        chk("counting", counting, 1'b1);
        cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b0);
        rd_chk(8'h9A);
        cpu.rd(16'hFF9C, d, v);
        chk("unmapped read", v, 1'b0);
        wait_req(8130);
        chk("early trip", wdt_reset_req, 1'b0);
        cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b0);
        wait_req(9000);
        chk("overflow", trip_cause.overflow, 1'b1);
        chk("period", n inside {[8150:8230]}, 1'b1);
        chk("flag", wd_reset_cause_flag, 1'b1);
        chk("cause bits", reset_cause_bits, 8'h10);
        @(posedge clk);
        cause_clr <= 1'b1;
        @(posedge clk);
        cause_clr <= 1'b0;
        @(posedge clk);
        #1;
        chk("flag cleared", wd_reset_cause_flag, 1'b0);
        $display("test overflow done");
        rst(8'h13, 3'b000);
        cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b0);
        wait_req(40);
        chk("first write", wdt_reset_req, 1'b0);
        cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b0);
        wait_req(40);
        chk("closed write", trip_cause.closed_write, 1'b1);
        rst(8'h70, 3'b100);
        chk("osc stopped", counting, 1'b0);
        cpu.wr(`WWDT_RESTART_ADDR, 8'h55, 1'b0);
        wait_req(40);
        chk("deferred", wdt_reset_req, 1'b0);
        @(posedge clk);
        slow_osc_stop_bit <= 1'b0;
        wait_req(40);
        chk("bad key", trip_cause.bad_key, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rst({7'h38, i[1]}, {1'b0, i[0], !i[0]});
            chk("halt count", counting, i[1]);
        end
        $display("test key and freeze done");
        // 50 and 75 percent windows: a key write 40 clk before the boundary trips, after does not
        for (int w = 1; w < 3; w++) begin
            for (int s = 0; s < 2; s++) begin
                rst({1'b0, w[1:0], 5'h11}, 3'b000);
                cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b0);
                wait_req(((1 << `WWDT_OVF_BASE) >> w) * 8 - 40 + 80 * s);
                cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b0);
                wait_req(40);
                chk("window edge", trip_cause.closed_write, !s);
            end
        end
        $display("test window done");
        rst(8'h71, 3'b000);
        cpu.wr(`WWDT_RESTART_ADDR, `WWDT_KEY, 1'b1);
        wait_req(40);
        chk("bit access", trip_cause.bit_access, 1'b1);
        rst(8'h71, 3'b000);
        cpu.acc(1'b0, 16'hFB10);
        cpu.acc(1'b1, 16'h8800);
        wait_req(10);
        chk("legal access", wdt_reset_req, 1'b0);
        cpu.acc(1'b1, 16'hFB10);
        wait_req(10);
        chk("bad fetch", trip_cause.bad_fetch, 1'b1);
        rst(8'h71, 3'b000);
        cpu.acc(1'b0, 16'h5000);
        wait_req(10);
        chk("bad data", trip_cause.bad_data, 1'b1);
        $display("test traps done");
        finish_test();
    end
endmodule : tb_wwdt_top

// *** tb/wwdt_cpu_model.sv ***
// cpu core model issuing register and memory accesses
`timescale 1ns/1ps
module wwdt_cpu_model (
    // clock
    input wire logic clk,
    // register bus
    output wwdt_pkg::wwdt_bus_type cpu_bus,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // memory accesses
    output logic fetch_valid,
    output logic [15:0] fetch_addr,
    output logic data_valid,
    output logic [15:0] data_addr
);
    import wwdt_pkg::*;
    initial begin
        cpu_bus = '0;
        fetch_valid = 1'b0;
        fetch_addr = 16'h0000;
        data_valid = 1'b0;
        data_addr = 16'h0000;
    end
    // a released bus shows inverted address and data lines, never their last value
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
        @(posedge clk);
        cpu_bus <= '{1'b1, 1'b0, b, a, d};
        @(posedge clk);
        cpu_bus <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        cpu_bus <= '{1'b0, 1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        cpu_bus <= '{1'b0, 1'b0, 1'b0, ~a, 8'hFF};
        #1;
        d = rd_data;
        v = rd_valid;
    endtask : rd
    task automatic acc(input logic f, input logic [15:0] a);
        @(posedge clk);
        fetch_valid <= f;
        data_valid <= !f;
        fetch_addr <= a;
        data_addr <= a;
        @(posedge clk);
        fetch_valid <= 1'b0;
        data_valid <= 1'b0;
        fetch_addr <= ~a;
        data_addr <= ~a;
        #1;
    endtask : acc
endmodule : wwdt_cpu_model

// *** tb/wwdt_properties.sv ***
// port assertions for the windowed watchdog
`timescale 1ns/1ps
`include "wwdt_consts.svh"
module wwdt_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // inputs watched
    input wire logic [7:0] option_cfg,
    input wire logic slow_osc_stop_bit,
    input wire logic cpu_halt,
    input wire logic cpu_stop,
    input wire wwdt_pkg::wwdt_bus_type cpu_bus,
    input wire wwdt_pkg::wwdt_map_type mem_map,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic data_valid,
    input wire logic [15:0] data_addr,
    // outputs watched
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic wdt_reset_req,
    input wire logic wd_reset_cause_flag,
    input wire logic [7:0] reset_cause_bits,
    input wire logic counting
);
    import wwdt_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    function automatic logic legal(logic [15:0] a, wwdt_map_type m);
        return a <= m.rom_top || (a >= m.xram_bot && a <= m.xram_top) || a >= m.iram_bot;
    endfunction : legal
    sequence s_rd_hit;
        cpu_bus.rd_en && cpu_bus.addr == `WWDT_RESTART_ADDR;
    endsequence
    sequence s_bad_fetch;
        counting && fetch_valid && !legal(fetch_addr, mem_map);
    endsequence
    sequence s_bad_data;
        counting && data_valid && !legal(data_addr, mem_map) && data_addr < `WWDT_EXEMPT_LO;
    endsequence
    AST_RD_VALID: assert property (s_rd_hit |=> rd_valid)
        else $error("restart read gave no data strobe");
    AST_RD_VALUE: assert property (s_rd_hit |=> rd_data == (option_cfg[4] ? 8'h9A : 8'h1A))
        else $error("restart read value wrong");
    AST_NO_KEY: assert property (rd_valid |-> rd_data != `WWDT_KEY)
        else $error("key value read back");
    AST_IDLE: assert property (!option_cfg[4] |-> !counting)
        else $error("counting while disabled");
    AST_CAUSE_BITS: assert property (reset_cause_bits == {3'h0, wd_reset_cause_flag, 4'h0})
        else $error("cause bits wrong");
    AST_FLAG: assert property ($rose(wdt_reset_req) |-> ##[0:1] wd_reset_cause_flag)
        else $error("cause flag not set");
    AST_PULSE: assert property (wdt_reset_req |=> !wdt_reset_req [*3])
        else $error("reset request not single");
    AST_FETCH: assert property (s_bad_fetch |=> wdt_reset_req)
        else $error("illegal fetch not caught");
    AST_DATA: assert property (s_bad_data |=> wdt_reset_req)
        else $error("illegal data access not caught");
    AST_FREEZE: assert property (!option_cfg[0] && (cpu_halt || cpu_stop || slow_osc_stop_bit)
        |-> !counting)
        else $error("counting while frozen");
endmodule : wwdt_chk

bind wwdt_top wwdt_chk chk_i (.clk, .srst, .option_cfg, .slow_osc_stop_bit, .cpu_halt,
    .cpu_stop, .cpu_bus, .mem_map, .fetch_valid, .fetch_addr, .data_valid, .data_addr,
    .rd_data, .rd_valid, .wdt_reset_req, .wd_reset_cause_flag, .reset_cause_bits, .counting);
